// >>> dv/pmic_irq_flags_and_masks_tb.sv
// Self-checking bench for the thermal flag, mask and limit register block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module pmic_irq_flags_and_masks_tb;
    import pmic_irq_pkg::*;
    logic       mclk_i, rst_i, reg_wr_i, reg_rd_i, wp, sup;
    logic [7:0] reg_addr_i, reg_wdata_i, d, ma, mb;
    logic [4:0] st, prev;
    logic [3:0] cf;
    logic [1:0] le;
    wire  [7:0] rdata;
    wire  [1:0] lim;
    wire        cirq, tirq;
    int         errors, num_checks, seed;

    pmic_irq_flags_and_masks u_pmic_irq_flags_and_masks (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
        .thermal_off_status_i(st), .write_protect_i(wp), .charger_input_supply_i(sup),
        .thermistor_change_flag_i(cf[3]), .current_limit_flag_i(cf[2]),
        .charger_thermreg_flag_i(cf[1]), .charger_timeout_flag_i(cf[0]),
        .input_limit_select_o(lim), .charger_irq_o(cirq), .thermal_irq_o(tirq));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Strobes change at the falling edge so the design samples settled values
    task automatic wr8(input logic [7:0] a, input logic [7:0] v);
        reg_addr_i = a; reg_wdata_i = v; reg_wr_i = 1'b1;
        @(negedge mclk_i); reg_wr_i = 1'b0;
        @(negedge mclk_i); // Idle edge keeps back-to-back strobes apart
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] v);
        reg_addr_i = a; reg_rd_i = 1'b1;
        @(negedge mclk_i); reg_rd_i = 1'b0; v = rdata;
        @(negedge mclk_i); // Idle edge keeps back-to-back strobes apart
    endtask

    function automatic logic cexp(logic [7:0] m, logic [3:0] f);
        return (m[7] & f[3]) | (m[5] & f[2]) | (m[1] & f[1]) | (m[0] & f[0]);
    endfunction

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000; // Whole run needs a few hundred cycles
        errors++;
        finish_test;
    end

    initial begin
        seed = 32'h81007011; errors = 0; num_checks = 0; rst_i = 1'b1;
        reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
        wp = 1'b0; sup = 1'b0; st = 5'h00; cf = 4'h0; le = 2'h0;
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        rd8(8'h07, d); `CHK("mask_a_rst", 8'hff, d)
        rd8(8'h08, d); `CHK("mask_b_rst", 8'h1f, d)
        rd8(8'h09, d); `CHK("limit_rst", 8'h00, d)
        rd8(8'h06, d); `CHK("flags_rst", 8'h00, d)
        rd8(8'h0a, d); `CHK("unmapped", 8'h00, d)
        for (int i = 0; i < 20; i++) begin
            mb = 8'($random(seed));
            wr8(8'h08, mb);
            rd8(8'h08, d); `CHK("mask_b", {3'h0, mb[4:0]}, d)
            prev = st; st = 5'($random(seed));
            @(negedge mclk_i);
            `CHK("thermal_irq", |((prev ^ st) & mb[4:0]), tirq)
            wr8(8'h06, 8'hff); // Flag register ignores writes
            rd8(8'h06, d); `CHK("flags", {3'h0, prev ^ st}, d)
            rd8(8'h06, d); `CHK("flags_clr", 8'h00, d)
            `CHK("thermal_irq_clr", 1'b0, tirq)
        end
        // Status flips in the very cycle of a flag read: the set must win
        st = ~st;
        rd8(8'h06, d); `CHK("flags_race_old", 8'h00, d)
        rd8(8'h06, d); `CHK("flags_race_new", 8'h1f, d)
        for (int i = 0; i < 24; i++) begin
            ma = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            wr8(8'h07, ma);
            cf = (i < 2) ? 4'hf : 4'($random(seed));
            @(negedge mclk_i);
            `CHK("charger_irq", cexp(ma, cf), cirq)
            rd8(8'h07, d); `CHK("mask_a", ma, d)
        end
        for (int i = 0; i < 10; i++) begin
            d = 8'($random(seed)); wp = i[0];
            if (!wp) le = d[1:0];
            wr8(8'h09, d);
            rd8(8'h09, d); `CHK("limit_rd", {6'h00, le}, d)
            `CHK("limit_out", le, lim)
        end
        wp = 1'b0; wr8(8'h09, 8'h03);
        `CHK("limit_set", 2'h3, lim)
        sup = 1'b1;
        repeat (2) @(negedge mclk_i);
        `CHK("limit_supply", 2'h0, lim)
        wr8(8'h09, 8'h02); sup = 1'b0;
        @(negedge mclk_i); sup = 1'b1;
        @(negedge mclk_i);
        rd8(8'h09, d); `CHK("limit_supply2", 8'h00, d)
        // Supply rise in the same cycle as a limit write: the rise wins
        sup = 1'b0;
        @(negedge mclk_i);
        sup = 1'b1; wr8(8'h09, 8'h03);
        `CHK("limit_rise_wins", 2'h0, lim)
        finish_test;
    end
endmodule

// >>> hw/pmic_irq_flags_and_masks.sv
// Thermal flags, interrupt masks and input current limit register
//
// Contract
// RULE1 - Thermal changes set flags; host read clears
// RULE2 - Mask A bit7 gates thermistor change flag
// RULE3 - Mask A bit1 gates thermal regulation flag
// RULE4 - Mask A bit0 gates charger timeout flag
// RULE5 - Mask A bit5 gates current limit flag
// RULE6 - Limit select writable unless write protected
// RULE7 - Limit select defaults on supply rise
// RULE8 - Thermal-off status bits drive event flags
// RULE9 - Mask B bits gate thermal flags
`timescale 1ns/1ns
module pmic_irq_flags_and_masks
    import pmic_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Device state
    input  wire logic [4:0] thermal_off_status_i,
    input  wire logic       write_protect_i,
    input  wire logic       charger_input_supply_i,
    // Raw charger event flags from the flag register outside
    input  wire logic       thermistor_change_flag_i,
    input  wire logic       current_limit_flag_i,
    input  wire logic       charger_thermreg_flag_i,
    input  wire logic       charger_timeout_flag_i,
    // Outputs
    output logic      [1:0] input_limit_select_o,
    output logic            charger_irq_o,
    output logic            thermal_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] status_r;
    logic [4:0] thermal_flags_r;
    logic [7:0] charger_event_mask_r;
    logic [4:0] thermal_event_mask_r;
    logic [1:0] input_limit_select_r;
    logic       supply_rise;
    logic       flag_rd;
    logic [4:0] status_change;
    logic       mask_a_wr;
    logic       mask_b_wr;
    logic       limit_wr;
    logic [7:0] rdata_nxt;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    assign flag_rd       = reg_rd_i & hit(reg_addr_i, THERMAL_EVENT_FLAGS_OFS);
    assign status_change = thermal_off_status_i ^ status_r; // see RULE8
    assign mask_a_wr     = reg_wr_i & hit(reg_addr_i, CHARGER_EVENT_MASK_OFS);
    assign mask_b_wr     = reg_wr_i & hit(reg_addr_i, THERMAL_EVENT_MASK_OFS);
    // Write protect guards only the limit, never the masks
    assign limit_wr      = reg_wr_i & ~write_protect_i
                         & hit(reg_addr_i, INPUT_CURRENT_LIMIT_OFS); // see RULE6

    rise_detect supply_edge (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .level_i (charger_input_supply_i),
        .rise_o  (supply_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status follower, reset value matches no thermal-off
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_r <= 5'h00;
        end else begin
            status_r <= thermal_off_status_i;
        end
    end

    // New change wins over a read in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            thermal_flags_r <= 5'h00;
        end else begin
            thermal_flags_r <= (flag_rd ? 5'h00 : thermal_flags_r) | status_change; // see RULE1
        end
    end

    // Unused charger mask bits are kept so a read returns what was written
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            charger_event_mask_r <= CHARGER_EVENT_MASK_RST;
        end else if (mask_a_wr) begin
            charger_event_mask_r <= reg_wdata_i; // see RULE2
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            thermal_event_mask_r <= THERMAL_EVENT_MASK_RST;
        end else if (mask_b_wr) begin
            thermal_event_mask_r <= reg_wdata_i[4:0]; // see RULE9
        end
    end

    // Supply rise beats a same-cycle write
    always_ff @(posedge mclk_i) begin
        if (rst_i || supply_rise) begin
            input_limit_select_r <= INPUT_LIMIT_SELECT_RST; // see RULE7
        end else if (limit_wr) begin
            input_limit_select_r <= reg_wdata_i[1:0]; // see RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped offsets read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr_i)
            THERMAL_EVENT_FLAGS_OFS: rdata_nxt = {3'h0, thermal_flags_r};
            CHARGER_EVENT_MASK_OFS:  rdata_nxt = charger_event_mask_r;
            THERMAL_EVENT_MASK_OFS:  rdata_nxt = {3'h0, thermal_event_mask_r};
            INPUT_CURRENT_LIMIT_OFS: rdata_nxt = {6'h00, input_limit_select_r};
            default:                 rdata_nxt = 8'h00;
        endcase
    end

    // Read data holds between reads
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    assign input_limit_select_o = input_limit_select_r;
    assign thermal_irq_o = |(thermal_flags_r & thermal_event_mask_r); // see RULE9
    assign charger_irq_o =
        (thermistor_change_flag_i & charger_event_mask_r[THERMISTOR_CHANGE_MASK_BIT]) // see RULE2
      | (charger_thermreg_flag_i  & charger_event_mask_r[CHARGER_THERMREG_MASK_BIT])  // see RULE3
      | (charger_timeout_flag_i   & charger_event_mask_r[CHARGER_TIMEOUT_MASK_BIT])   // see RULE4
      | (current_limit_flag_i     & charger_event_mask_r[CURRENT_LIMIT_MASK_BIT]);    // see RULE5

    ////////////////////////////////////////////////////////////////////////
    flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        (thermal_off_status_i[BUCK_A_BIT] != status_r[BUCK_A_BIT])
        |=> thermal_flags_r[BUCK_A_BIT])
        else $error("Thermal change did not set flag");
    flag_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        flag_rd && (status_change == 5'h00) |=> thermal_flags_r == 5'h00)
        else $error("Flag read did not clear");
    flag_cause_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE8
        $rose(thermal_flags_r[LINREG_C_BIT]) |-> $past(status_change[LINREG_C_BIT]))
        else $error("Flag set without status change");
    thermistor_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE2
        !charger_event_mask_r[THERMISTOR_CHANGE_MASK_BIT] && thermistor_change_flag_i
        && !charger_thermreg_flag_i && !charger_timeout_flag_i && !current_limit_flag_i
        |-> !charger_irq_o)
        else $error("Masked thermistor flag leaked");
    thermreg_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE3
        charger_event_mask_r[CHARGER_THERMREG_MASK_BIT] && charger_thermreg_flag_i
        |-> charger_irq_o)
        else $error("Unmasked thermal regulation flag lost");
    timeout_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE4
        charger_event_mask_r[CHARGER_TIMEOUT_MASK_BIT] && charger_timeout_flag_i
        |-> charger_irq_o)
        else $error("Unmasked timeout flag lost");
    ilim_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE5
        charger_event_mask_r[CURRENT_LIMIT_MASK_BIT] && current_limit_flag_i
        |-> charger_irq_o)
        else $error("Unmasked current limit flag lost");
    limit_protect_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE6
        write_protect_i && !supply_rise |=> $stable(input_limit_select_r))
        else $error("Protected limit select changed");
    limit_default_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE7
        supply_rise |=> input_limit_select_o == INPUT_LIMIT_SELECT_RST)
        else $error("Supply rise did not restore limit");
    thermal_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE9
        (thermal_flags_r & thermal_event_mask_r) == 5'h00 |-> !thermal_irq_o)
        else $error("Masked thermal flag leaked");

    // Flag set, hold and read back on every regulator bit
    flag_any_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        status_change != 5'h00
        |=> (thermal_flags_r & $past(status_change)) == $past(status_change))
        else $error("Thermal change lost against a read");
    flag_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        !flag_rd && status_change == 5'h00 |=> $stable(thermal_flags_r))
        else $error("Thermal flags changed without cause");
    flag_read_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        flag_rd |=> reg_rdata_o == {3'h0, $past(thermal_flags_r)})
        else $error("Flag read returned wrong value");
    rdata_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE1
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("Read data moved without a read");

    // Register writes land one cycle later
    mask_a_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE2
        mask_a_wr |=> charger_event_mask_r == $past(reg_wdata_i))
        else $error("Charger mask write lost");
    mask_b_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE9
        mask_b_wr |=> thermal_event_mask_r == $past(reg_wdata_i[4:0]))
        else $error("Thermal mask write lost");
    limit_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE6
        limit_wr && !supply_rise |=> input_limit_select_r == $past(reg_wdata_i[1:0]))
        else $error("Unprotected limit write lost");

    // Unmasked sources must reach their interrupt
    thermal_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE9
        (thermal_flags_r & thermal_event_mask_r) != 5'h00 |-> thermal_irq_o)
        else $error("Unmasked thermal flag lost");
    thermistor_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see RULE2
        charger_event_mask_r[THERMISTOR_CHANGE_MASK_BIT] && thermistor_change_flag_i
        |-> charger_irq_o)
        else $error("Unmasked thermistor flag lost");

    flag_read_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        thermal_flags_r != 5'h00 ##1 flag_rd);
    limit_write_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        reg_wr_i && !write_protect_i && hit(reg_addr_i, INPUT_CURRENT_LIMIT_OFS));
    thermal_irq_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(thermal_irq_o));
    supply_rise_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        supply_rise && limit_wr);
    charger_irq_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        $rose(charger_irq_o));
endmodule

// >>> hw/pmic_irq_pkg.sv
// Register map and constants for the regulator interrupt flag and mask block
package pmic_irq_pkg;
    localparam logic [7:0] THERMAL_EVENT_FLAGS_OFS = 8'h06;
    localparam logic [7:0] CHARGER_EVENT_MASK_OFS  = 8'h07;
    localparam logic [7:0] THERMAL_EVENT_MASK_OFS  = 8'h08;
    localparam logic [7:0] INPUT_CURRENT_LIMIT_OFS = 8'h09;
    // Field positions in the charger event mask
    localparam int THERMISTOR_CHANGE_MASK_BIT = 7;
    localparam int CURRENT_LIMIT_MASK_BIT     = 5;
    localparam int CHARGER_THERMREG_MASK_BIT  = 1;
    localparam int CHARGER_TIMEOUT_MASK_BIT   = 0;
    // Regulator order in flag, mask and status vectors
    localparam int BUCK_A_BIT   = 4;
    localparam int BUCK_B_BIT   = 3;
    localparam int LINREG_A_BIT = 2;
    localparam int LINREG_B_BIT = 1;
    localparam int LINREG_C_BIT = 0;
    localparam int NUM_REGS     = 5;
    // Reset values
    localparam logic [7:0] CHARGER_EVENT_MASK_RST = 8'hff;
    localparam logic [4:0] THERMAL_EVENT_MASK_RST = 5'h1f;
    localparam logic [1:0] INPUT_LIMIT_SELECT_RST = 2'h0;
endpackage

// >>> hw/rise_detect.sv
// Rising edge detector with one registered stage
`timescale 1ns/1ns
module rise_detect (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Level in, pulse out
    input  wire logic level_i,
    output logic      rise_o
);
    logic level_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_i;
        end
    end

    // Reset seeds low, so a supply already up at release counts as a rise
    assign rise_o = level_i & ~level_r;
endmodule
